// File: hdl/pbfc_pkg.sv
// Constants and carriers of the port backpressure flow control block
package pbfc_pkg;
  // Sizes
  localparam int NPORT = 26;
  localparam int PW    = 5;
  localparam int QW    = 8;
  localparam int TW    = 16;
  localparam int AW    = 12;
  localparam logic [PW-1:0] PORT_LIM = PW'(NPORT);

  // Address fields: word index and block select
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 6;
  localparam int BLK_LSB = 7;

  // Register byte offsets
  localparam logic [AW-1:0] CFG_BASE  = 12'h000;
  localparam logic [AW-1:0] THR_BASE  = 12'h080;
  localparam logic [AW-1:0] IRQ_STAT  = 12'h100;
  localparam logic [AW-1:0] IRQ_EN    = 12'h104;
  localparam logic [AW-1:0] IRQ_CLR   = 12'h108;
  localparam logic [AW-1:0] CONG_STAT = 12'h10C;

  // Reset values and writable bits
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h0000_000F;
  localparam logic [31:0] THR_RST  = 32'h0000_00FF;

  // Bus answers
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // Window time base: one window unit in ns, clock period in ns
  localparam int WIN_UNIT_NS = 1000;
  localparam int CLK_NS      = 100;
  localparam int WIN_UNIT_CYC = (WIN_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(WIN_UNIT_CYC - 1);

  // Port flow configuration register
  typedef struct packed {
    logic [27:0] rsvd;
    logic        bcast_fc_off;
    logic        per_port;
    logic        full_duplex;
    logic        fc_en;
  } pbfc_cfg_t;

  // Backpressure threshold register
  typedef struct packed {
    logic [TW-1:0] fc_time;
    logic [QW-1:0] low_mark;
    logic [QW-1:0] high_mark;
  } pbfc_thr_t;

  // Lookup result seen on the switching bus
  typedef struct packed {
    logic [PW-1:0]    src;
    logic [NPORT-1:0] dst;
    logic             bcast;
  } pbfc_lkp_t;
endpackage

// File: hdl/pbfc_top.sv
// Per-port backpressure sensing and flow control behind AXI4-Lite
`timescale 1ns/1ns
module pbfc_top
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  input  wire logic [pbfc_pkg::AW-1:0]       awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [pbfc_pkg::AW-1:0]       araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic                          lkp_valid,
  input  wire pbfc_pkg::pbfc_lkp_t           lkp,
  input  wire logic [pbfc_pkg::NPORT-1:0]    txq_push,
  input  wire logic [pbfc_pkg::NPORT-1:0]    txq_pop,
  input  wire logic [pbfc_pkg::NPORT-1:0]    rx_start,
  output logic                               bp_line,
  output logic [pbfc_pkg::NPORT-1:0]         drop_pkt,
  output logic [pbfc_pkg::NPORT-1:0]         drop_copy,
  output logic [pbfc_pkg::NPORT-1:0]         pause_req,
  output logic [pbfc_pkg::TW-1:0]            pause_time,
  output logic [pbfc_pkg::NPORT-1:0]         force_col,
  output logic                               irq
);
  localparam int N  = pbfc_pkg::NPORT;
  localparam int AW = pbfc_pkg::AW;

  pbfc_pkg::pbfc_cfg_t        cfg  [N];
  pbfc_pkg::pbfc_thr_t        thr  [N];
  logic [pbfc_pkg::QW-1:0]    qcnt [N];
  logic [pbfc_pkg::TW-1:0]    win  [N];
  logic [N-1:0]               cong;
  logic [N-1:0]               cong_set;
  logic [N-1:0]               irq_stat;
  logic [N-1:0]               irq_en;
  logic [N-1:0]               clr_mask;
  logic [N-1:0]               win_open;
  logic [pbfc_pkg::TICK_W-1:0] tick_cnt;
  logic                       tick;
  logic [AW-1:0]              aw_q;
  logic [31:0]                w_q;
  logic [3:0]                 ws_q;
  logic                       wr_fire;
  logic [pbfc_pkg::PW-1:0]    widx;
  logic [31:0]                rd_mux;
  logic [31:0]                clr_word;
  logic [31:0]                en_word;
  logic [N-1:0]               hit_map;
  logic [N-1:0]               src_map;
  logic                       hit_any;
  logic                       src_ok;
  logic                       bdis;
  logic                       act;
  pbfc_pkg::pbfc_cfg_t        scfg;
  pbfc_pkg::pbfc_thr_t        sthr;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // Per-port register block hit
  function automatic logic in_blk(input logic [AW-1:0] a,
                                  input logic [AW-1:0] base);
    return a[AW-1:pbfc_pkg::BLK_LSB] == base[AW-1:pbfc_pkg::BLK_LSB] &&
           a[pbfc_pkg::IDX_MSB:pbfc_pkg::IDX_LSB] < pbfc_pkg::PORT_LIM &&
           a[pbfc_pkg::IDX_LSB-1:0] == '0;
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return in_blk(a, pbfc_pkg::CFG_BASE) || in_blk(a, pbfc_pkg::THR_BASE) ||
           a == pbfc_pkg::IRQ_STAT || a == pbfc_pkg::IRQ_EN ||
           a == pbfc_pkg::IRQ_CLR || a == pbfc_pkg::CONG_STAT;
  endfunction

  // Lookup decode: settings of the named source port only, congestion of the destination ports
  always_comb
  begin
    src_ok  = lkp.src < pbfc_pkg::PORT_LIM;
    src_map = src_ok ? (N'(1) << lkp.src) : '0;
    scfg    = src_ok ? cfg[lkp.src] : '0;
    sthr    = src_ok ? thr[lkp.src] : '0;
    hit_map = lkp.dst & cong;
    hit_any = |hit_map;
    bdis    = lkp.bcast & scfg.bcast_fc_off;
    act     = lkp_valid & src_ok & hit_any & ~bdis;
  end

  // Line drive and source reaction, registered on the cycle after the lookup
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      bp_line    <= 1'b0;
      drop_pkt   <= '0;
      drop_copy  <= '0;
      pause_req  <= '0;
      pause_time <= '0;
      force_col  <= '0;
    end
    else if (ce)
    begin
      bp_line   <= lkp_valid & hit_any;
      drop_copy <= (lkp_valid & bdis) ? hit_map : '0;
      drop_pkt  <= (act & ~scfg.fc_en) ? src_map : '0;
      pause_req <= (act & scfg.fc_en & scfg.full_duplex)
                   ? src_map : '0;
      if (act & scfg.fc_en & scfg.full_duplex)
        pause_time <= sthr.fc_time;
      force_col <= ((act & scfg.fc_en & ~scfg.full_duplex &
                     ~scfg.per_port) ? src_map : '0)
                   | (rx_start & win_open);
    end

  // Window time base
  assign tick = tick_cnt == pbfc_pkg::TICK_LAST;
  always_ff @(posedge aclk)
    if (!aresetn)
      tick_cnt <= '0;
    else if (ce)
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;

  // Per-port collision windows
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      for (int p = 0; p < N; p++)
        win[p] <= '0;
    end
    else if (ce)
    begin
      for (int p = 0; p < N; p++)
        if (act && src_map[p] && scfg.fc_en && !scfg.full_duplex &&
            scfg.per_port)
          win[p] <= thr[p].fc_time;
        else if (tick && win[p] != '0)
          win[p] <= win[p] - 1'b1;
    end

  always_comb
    for (int p = 0; p < N; p++)
      win_open[p] = win[p] != '0;

  // Transmit queue packet counts
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      for (int p = 0; p < N; p++)
        qcnt[p] <= '0;
    end
    else if (ce)
    begin
      for (int p = 0; p < N; p++)
        qcnt[p] <= qcnt[p] + pbfc_pkg::QW'(txq_push[p])
                   - pbfc_pkg::QW'(txq_pop[p]);
    end

  // Congestion with hysteresis
  always_comb
    for (int p = 0; p < N; p++)
      cong_set[p] = ~cong[p] & (qcnt[p] > thr[p].high_mark);

  always_ff @(posedge aclk)
    if (!aresetn)
      cong <= '0;
    else if (ce)
    begin
      for (int p = 0; p < N; p++)
        if (qcnt[p] > thr[p].high_mark)
          cong[p] <= 1'b1;
        else if (qcnt[p] < thr[p].low_mark)
          cong[p] <= 1'b0;
    end

  // Sticky congestion events; a new event beats a clear
  assign clr_word = merge('0, w_q, ws_q);
  assign en_word  = merge(32'(irq_en), w_q, ws_q);
  assign clr_mask = (wr_fire && aw_q == pbfc_pkg::IRQ_CLR)
                    ? clr_word[N-1:0] : '0;
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end
    else if (ce)
    begin
      irq_stat <= (irq_stat & ~clr_mask) | cong_set;
      irq      <= |(irq_stat & irq_en);
    end

  // AXI write channels: address and data in any order
  assign wr_fire = ce & ~awready & ~wready & ~bvalid;
  assign widx    = aw_q[pbfc_pkg::IDX_MSB:pbfc_pkg::IDX_LSB];
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= pbfc_pkg::RESP_OK;
      aw_q    <= '0;
      w_q     <= '0;
      ws_q    <= '0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_q    <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_q    <= wdata;
        ws_q   <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp  <= mapped(aw_q) ? pbfc_pkg::RESP_OK : pbfc_pkg::RESP_ERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end

  // Software-written registers, one set per port
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      for (int p = 0; p < N; p++)
      begin
        cfg[p] <= pbfc_pkg::CFG_RST;
        thr[p] <= pbfc_pkg::THR_RST;
      end
      irq_en <= '0;
    end
    else if (wr_fire)
    begin
      for (int p = 0; p < N; p++)
      begin
        if (in_blk(aw_q, pbfc_pkg::CFG_BASE) && widx == pbfc_pkg::PW'(p))
          cfg[p] <= merge(cfg[p], w_q, ws_q) & pbfc_pkg::CFG_MASK;
        if (in_blk(aw_q, pbfc_pkg::THR_BASE) && widx == pbfc_pkg::PW'(p))
          thr[p] <= merge(thr[p], w_q, ws_q);
      end
      if (aw_q == pbfc_pkg::IRQ_EN)
        irq_en <= en_word[N-1:0];
    end

  // Read data select
  always_comb
  begin
    rd_mux = '0;
    if (in_blk(araddr, pbfc_pkg::CFG_BASE))
      rd_mux = cfg[araddr[pbfc_pkg::IDX_MSB:pbfc_pkg::IDX_LSB]];
    else if (in_blk(araddr, pbfc_pkg::THR_BASE))
      rd_mux = thr[araddr[pbfc_pkg::IDX_MSB:pbfc_pkg::IDX_LSB]];
    else if (araddr == pbfc_pkg::IRQ_STAT)
      rd_mux = 32'(irq_stat);
    else if (araddr == pbfc_pkg::IRQ_EN)
      rd_mux = 32'(irq_en);
    else if (araddr == pbfc_pkg::CONG_STAT)
      rd_mux = 32'(cong);
  end

  // AXI read channel
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= pbfc_pkg::RESP_OK;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_mux;
        rresp   <= mapped(araddr) ? pbfc_pkg::RESP_OK : pbfc_pkg::RESP_ERR;
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end

  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hit;
    ce && lkp_valid && hit_any;
  endsequence
  sequence s_act;
    ce && act;
  endsequence

  AST_BP_LINE: assert property (s_hit |=> bp_line)
    else $error("congested hit did not raise the line");
  AST_BP_QUIET: assert property (ce && !(lkp_valid && hit_any) |=> !bp_line)
    else $error("line raised without a congested hit");
  AST_ONLY_SRC: assert property (ce && lkp_valid |=>
      ((drop_pkt | pause_req) & ~$past(src_map)) == '0)
    else $error("a port other than the source reacted");
  AST_DROP: assert property (s_act ##0 !scfg.fc_en |=>
      drop_pkt == $past(src_map) && pause_req == '0)
    else $error("packet not dropped with flow control off");
  AST_PAUSE: assert property (s_act ##0 (scfg.fc_en && scfg.full_duplex)
      |=> pause_req == $past(src_map) &&
          pause_time == $past(sthr.fc_time))
    else $error("pause request or time wrong");
  AST_COLL: assert property (s_act ##0 (scfg.fc_en && !scfg.full_duplex &&
      !scfg.per_port) |=> (force_col & $past(src_map)) != '0)
    else $error("per-packet collision missing");
  AST_PASS: assert property (ce && lkp_valid && !hit_any |=>
      drop_pkt == '0 && pause_req == '0 && drop_copy == '0)
    else $error("uncongested lookup was acted on");
  AST_BCAST: assert property (ce && lkp_valid && bdis |=>
      drop_copy == $past(hit_map) && drop_pkt == '0 &&
      pause_req == '0)
    else $error("broadcast copy handling wrong");
  AST_RESET: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> !bp_line && cong == '0 && force_col == '0)
    else $error("state not clear after reset");

  for (genvar g = 0; g < N; g++)
  begin : g_chk
    AST_ENTER: assert property (ce && qcnt[g] > thr[g].high_mark |=> cong[g])
      else $error("port missed congestion entry");
    AST_LEAVE: assert property ($fell(cong[g]) |->
        $past(ce) && $past(qcnt[g]) < $past(thr[g].low_mark))
      else $error("port left congestion above low mark");
    AST_WIN: assert property (ce && rx_start[g] && win_open[g] |=>
        force_col[g])
      else $error("arrival in window not collided");
  end
endmodule

// File: tb/pbfc_link_partner.sv
// Link partner model: starts packets, counts pauses and collisions
`timescale 1ns/1ns
module pbfc_link_partner
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [pbfc_pkg::NPORT-1:0] send,
  input  wire logic [pbfc_pkg::NPORT-1:0] pause_req,
  input  wire logic [pbfc_pkg::NPORT-1:0] force_col,
  output logic      [pbfc_pkg::NPORT-1:0] rx_start,
  output int                              pause_cnt,
  output int                              col_cnt
);
  // Packet starts go out one cycle after the request, events are tallied
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_start  <= '0;
      pause_cnt <= 0;
      col_cnt   <= 0;
    end
    else
    begin
      rx_start  <= send;
      pause_cnt <= pause_cnt + $countones(pause_req);
      col_cnt   <= col_cnt + $countones(force_col);
    end
  end
endmodule

// File: tb/pbfc_top_tb.sv
// Self-checking bench of the backpressure flow control block
`timescale 1ns/1ns
module pbfc_top_tb;
  logic                aclk, aresetn, awvalid, wvalid, bready;
  logic                arvalid, rready, lkp_valid;
  logic [11:0]         awaddr, araddr;
  logic [31:0]         wdata, rd;
  logic [3:0]          wstrb;
  logic [1:0]          rs;
  pbfc_pkg::pbfc_lkp_t lkp;
  logic [25:0]         txq_push, txq_pop, send;
  wire                 awready, wready, bvalid, arready, rvalid;
  wire                 bp_line, irq;
  wire  [1:0]          bresp, rresp;
  wire  [31:0]         rdata;
  wire  [25:0]         rx_start, drop_pkt, drop_copy, pause_req, force_col;
  wire  [15:0]         pause_time;
  int                  pause_cnt, col_cnt, miscompares, num_checks, c0;

  pbfc_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .lkp_valid(lkp_valid), .lkp(lkp),
    .txq_push(txq_push), .txq_pop(txq_pop), .rx_start(rx_start),
    .bp_line(bp_line), .drop_pkt(drop_pkt), .drop_copy(drop_copy),
    .pause_req(pause_req), .pause_time(pause_time),
    .force_col(force_col), .irq(irq));
  pbfc_link_partner lp (.aclk(aclk), .aresetn(aresetn), .send(send),
    .pause_req(pause_req), .force_col(force_col), .rx_start(rx_start),
    .pause_cnt(pause_cnt), .col_cnt(col_cnt));

  // Clock of 100 ns
  initial
  begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Bus write: address and data offered together, released when taken
  task axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
  endtask

  // Bus read: address held until taken, data taken with rvalid
  task axr(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  // One lookup pulse; outputs sampled mid-cycle after it is taken
  task lk(input logic [4:0] s, input logic [25:0] d, input logic b);
    @(posedge aclk);
    lkp_valid <= 1'h1;
    lkp <= '{src: s, dst: d, bcast: b};
    @(posedge aclk);
    lkp_valid <= 1'h0;
    @(negedge aclk);
  endtask

  // Queue push and pop pulses, then time for congestion to settle
  task q(input logic [25:0] pu, input logic [25:0] po, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      txq_push <= pu;
      txq_pop <= po;
      @(posedge aclk);
      txq_push <= '0;
      txq_pop <= '0;
    end
    repeat (3) @(posedge aclk);
  endtask

  task t_reset;
    chk("bp_line", 32'(bp_line), 32'h0000_0000);
    axr(pbfc_pkg::CFG_BASE);
    chk("cfg", rd, pbfc_pkg::CFG_RST);
    axr(pbfc_pkg::THR_BASE);
    chk("thr", rd, pbfc_pkg::THR_RST);
    axr(pbfc_pkg::CONG_STAT);
    chk("cong", rd, 32'h0000_0000);
    axr(12'h200);
    chk("unmapped", 32'(rs), 32'(pbfc_pkg::RESP_ERR));
    axw(12'h200, 32'h0000_0000);
    chk("unmapped wr", 32'(rs), 32'(pbfc_pkg::RESP_ERR));
  endtask

  task t_cong;
    axw(pbfc_pkg::THR_BASE + 12'h00C, 32'h0002_0102);
    chk("thr bresp", 32'(rs), 32'(pbfc_pkg::RESP_OK));
    axw(pbfc_pkg::IRQ_EN, 32'h0000_0008);
    q(26'h000_0018, '0, 2);
    axr(pbfc_pkg::CONG_STAT);
    chk("cong at mark", rd, 32'h0000_0000);
    q(26'h000_0018, '0, 1);
    axr(pbfc_pkg::CONG_STAT);
    chk("cong above", rd, 32'h0000_0008);
    chk("irq set", 32'(irq), 32'h0000_0001);
    axw(pbfc_pkg::IRQ_CLR, 32'h0000_0008);
    repeat (2) @(posedge aclk);
    chk("irq clear", 32'(irq), 32'h0000_0000);
  endtask

  // Discard, pause and per-packet collision on the source port only
  task t_actions;
    logic [31:0] cf;
    // Source port 1 owns the pause time and window length; no congestion
    axw(pbfc_pkg::THR_BASE + 12'h004, 32'h0002_00FF);
    for (int i = 0; i < 3; i++)
    begin
      cf = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'h0000_0003 : 32'h1;
      axw(pbfc_pkg::CFG_BASE + 12'h004, cf);
      lk(5'h01, 26'h000_0008, 1'h0);
      chk("bp_line", 32'(bp_line), 32'h0000_0001);
      chk("drop", 32'(drop_pkt), (i == 0) ? 32'h2 : 32'h0);
      chk("pause", 32'(pause_req), (i == 1) ? 32'h2 : 32'h0);
      chk("col", 32'(force_col), (i == 2) ? 32'h2 : 32'h0);
      if (i == 1)
        chk("pause_time", 32'(pause_time), 32'h0000_0002);
    end
    chk("pauses seen", pause_cnt, 32'h0000_0001);
    lk(5'h01, 26'h000_0010, 1'h0);
    chk("free bp", 32'(bp_line), 32'h0000_0000);
    chk("free col", 32'(force_col), 32'h0000_0000);
  endtask

  task t_bcast;
    axw(pbfc_pkg::CFG_BASE + 12'h004, 32'h0000_0009);
    lk(5'h01, 26'h000_0019, 1'h1);
    chk("copy", 32'(drop_copy), 32'h0000_0008);
    chk("bc drop", 32'(drop_pkt), 32'h0000_0000);
    chk("bc col", 32'(force_col), 32'h0000_0000);
  endtask

  // Per-port window: first packet passes, arrivals in the window collide, one after it does not
  task t_window;
    axw(pbfc_pkg::CFG_BASE + 12'h004, 32'h0000_0005);
    lk(5'h01, 26'h000_0008, 1'h0);
    chk("win now", 32'(force_col), 32'h0000_0000);
    chk("win drop", 32'(drop_pkt), 32'h0000_0000);
    c0 = col_cnt;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge aclk);
      send <= 26'h000_0002;
      @(posedge aclk);
      send <= '0;
      repeat (k == 0 ? 5 : 30) @(posedge aclk);
    end
    chk("win cols", col_cnt, 32'(c0 + 2));
    @(posedge aclk);
    send <= 26'h000_0002;
    @(posedge aclk);
    send <= '0;
    repeat (5) @(posedge aclk);
    chk("win closed", col_cnt, 32'(c0 + 2));
  endtask

  task t_release;
    q('0, 26'h000_0018, 2);
    axr(pbfc_pkg::CONG_STAT);
    chk("cong hold", rd, 32'h0000_0008);
    q('0, 26'h000_0008, 1);
    axr(pbfc_pkg::CONG_STAT);
    chk("cong left", rd, 32'h0000_0000);
  endtask

  // Main sequence after a five cycle reset
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, lkp_valid} = '0;
    {awaddr, araddr, wdata, lkp, txq_push, txq_pop, send} = '0;
    wstrb = 4'hF;
    miscompares = 0;
    num_checks = 0;
    aresetn = 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_cong();
    t_actions();
    t_bcast();
    t_window();
    t_release();
    finish_test();
  end

  // Watchdog on a hung handshake
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test();
  end
endmodule
